// ### rtl/pci_bus_request_arbiter.sv
// internal arbiter of the secondary bus: grants, fairness, broken-master handling
// Overview of operation
// - each of the five requesters has an enable bit 0..4, reset to one, and a cleared bit keeps it out.
// - bit 9 at zero lets this arbiter drive grants, at one it stands aside for an outside arbiter.
// - with bit 10 set, sixteen idle cycles of a held grant without FRAME# count toward a timeout.
// - with bit 11 clear a timed-out requester is ignored for good once it drops REQ# for a clock.
// - with bit 11 set the broken state is cleared after every other requester was served once.
// - bits 19:12, reset 08h, give the cycles a grant is held after another request shows up.
// - the fairness counter reloads from bits 19:12 on every new grant.
// - the fairness counter only starts to count down after the next fall of FRAME#.
// - a fairness value of zero holds the grant until the owner drops its REQ#.
// - with bit 20 clear the grant stays asserted after the owner starts its frame.
// - with bit 20 set the grant is removed for one clock, two clocks after FRAME# falls.
// - bits 22..26 give each requester a high (one) or low (zero) priority level.
// - after reset the internal requester is high priority and masters 1 to 4 low.
//
// Chosen here: strobed register access.
`default_nettype none
module pci_bus_request_arbiter (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	input  wire logic        int_req,
	input  wire logic [3:0]  req_n,
	input  wire logic        frame_n,
	input  wire logic        irdy_n,
	input  wire logic        ext_gnt_n,
	output logic             int_gnt,
	output logic [3:0]       gnt_n,
	output logic             ext_req_n,
	output logic             ext_arb_sel
);
	import arb_pkg::*;

	arb_pkg::ctrl_t ctrl;
	arb_pkg::stat_t stat;

	// registers seen by software
	arb_regs arb_regs_i (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.stat      (stat),
		.reg_rdata (reg_rdata),
		.ctrl      (ctrl)
	);

	arb_state_t         state_ff;
	arb_state_t         nxt_state;
	logic [IDX_W-1:0]   owner_ff;
	logic [IDX_W-1:0]   nxt_owner;
	logic [NREQ-1:0]    gnt_ff;
	logic [NREQ-1:0]    nxt_gnt;
	logic [NREQ-1:0]    tmo_ff;
	logic [NREQ-1:0]    broken_ff;
	logic [NREQ-1:0]    served_ff;
	logic [FAIR_W-1:0]  fair_cnt_ff;
	logic [3:0]         bm_cnt_ff;
	logic               frame_prev_ff;
	logic               int_gnt_ff;
	logic [3:0]         gnt_n_ff;
	logic               ext_req_n_ff;
	logic               ext_sel_ff;

	logic [NREQ-1:0]    req;
	logic [NREQ-1:0]    owner_oh;
	logic [NREQ-1:0]    elig;
	logic               frame_fall;
	logic               bus_idle;
	logic               other_req;
	logic               own_drop;
	logic               own_off;
	logic               bm_tmo;
	logic               fair_out;
	logic               release_gnt;
	logic               pick_valid;
	logic [IDX_W-1:0]   pick_idx;
	logic               new_grant;
	logic               tog_gap;
	logic               faulty_any;
	logic               all_served;

	// requests active high, internal requester at bit 0
	assign req        = {~req_n, int_req};
	assign owner_oh   = idx_onehot(owner_ff);
	assign frame_fall = frame_prev_ff & ~frame_n;
	assign bus_idle   = frame_n & irdy_n;

	// disabled, timed-out and broken requesters take no part
	assign elig = req & ctrl.en & ~(tmo_ff | broken_ff) & {NREQ{~ctrl.ext}};

	// next owner out of the eligible set
	arb_pick arb_pick_i (
		.elig  (elig),
		.prio  (ctrl.prio),
		.last  (owner_ff),
		.valid (pick_valid),
		.idx   (pick_idx)
	);

	// someone else waits while the current owner holds the grant
	assign other_req = |(elig & ~owner_oh);

	// owner gave up the bus, or may no longer hold it
	assign own_drop = ~|(req & owner_oh);
	assign own_off  = ~|(ctrl.en & owner_oh) | ctrl.ext;

	// grant held on an idle bus for the full count with no frame
	assign bm_tmo = ctrl.bm_en && state_ff == ST_WAIT && bus_idle && bm_cnt_ff == BM_LAST;

	// fairness ran out and another requester is waiting; zero never runs out
	assign fair_out = ctrl.fair != 8'h00 && state_ff == ST_OWN && fair_cnt_ff == 8'h00 && other_req;

	assign release_gnt = own_drop | own_off | bm_tmo | fair_out;
	assign new_grant   = state_ff == ST_IDLE && pick_valid;

	// one-clock gap two clocks after the owner's frame began; the grant goes
	// through two flops to the pin, so the gap is decided in the frame's first cycle
	assign tog_gap = ctrl.tog && state_ff == ST_WAIT && frame_fall;

	// owner changes only through an idle cycle, so two grants never overlap
	always_comb begin
		nxt_state = state_ff;
		nxt_owner = owner_ff;
		case (state_ff)
			ST_IDLE: begin
				if (pick_valid) begin
					nxt_state = ST_WAIT;
					nxt_owner = pick_idx;
				end
			end
			ST_WAIT: begin
				if (release_gnt) begin
					nxt_state = ST_IDLE;
				end else if (frame_fall) begin
					nxt_state = ST_OWN;
				end
			end
			ST_OWN: begin
				if (release_gnt) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// grant vector as it will stand in the next cycle
	always_comb begin
		if (nxt_state == ST_IDLE || tog_gap) begin
			nxt_gnt = '0;
		end else begin
			nxt_gnt = idx_onehot(nxt_owner);
		end
	end

	// arbitration state and owner
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_ff <= ST_IDLE;
			owner_ff <= 3'h0;
			gnt_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			owner_ff <= nxt_owner;
			gnt_ff   <= nxt_gnt;
		end
	end

	// previous FRAME# level for fall detection
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			frame_prev_ff <= 1'b1;
		end else begin
			frame_prev_ff <= frame_n;
		end
	end

	// fairness counter: reload per grant, count only once the frame has begun
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fair_cnt_ff <= 8'h08;
		end else if (new_grant) begin
			fair_cnt_ff <= ctrl.fair;
		end else if (state_ff == ST_OWN && other_req && fair_cnt_ff != 8'h00) begin
			fair_cnt_ff <= fair_cnt_ff - 8'h01;
		end
	end

	// broken-master count of idle cycles without a frame
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bm_cnt_ff <= 4'h0;
		end else if (state_ff != ST_WAIT) begin
			bm_cnt_ff <= 4'h0;
		end else if (ctrl.bm_en && bus_idle && bm_cnt_ff != BM_LAST) begin
			bm_cnt_ff <= bm_cnt_ff + 4'h1;
		end
	end

	// a requester counts as faulty while timed out or broken
	assign faulty_any = |(tmo_ff | broken_ff);
	assign all_served = &(served_ff | ~ctrl.en | tmo_ff | broken_ff);

	// timed-out owners wait for a REQ# drop; refresh clears all faults once
	// every healthy requester has had a turn, which keeps a flaky master from starving others
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tmo_ff    <= '0;
			broken_ff <= '0;
		end else if (ctrl.bm_ref && faulty_any && all_served) begin
			// a timeout in the refresh cycle still marks its owner
			tmo_ff    <= bm_tmo ? owner_oh : '0;
			broken_ff <= '0;
		end else begin
			for (int i = 0; i < NREQ; i++) begin
				if (bm_tmo && owner_oh[i]) begin
					tmo_ff[i] <= 1'b1;
				end else if (tmo_ff[i] && !req[i] && !ctrl.bm_ref) begin
					tmo_ff[i]    <= 1'b0;
					broken_ff[i] <= 1'b1;
				end
			end
		end
	end

	// grants handed out since the last fault refresh
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			served_ff <= '0;
		end else if (!faulty_any || (ctrl.bm_ref && all_served)) begin
			served_ff <= '0;
		end else if (new_grant) begin
			served_ff <= served_ff | idx_onehot(pick_idx);
		end
	end

	// pins: in outside-arbiter mode the internal requester goes out and back
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			int_gnt_ff   <= 1'b0;
			gnt_n_ff     <= 4'hf;
			ext_req_n_ff <= 1'b1;
			ext_sel_ff   <= 1'b0;
		end else begin
			int_gnt_ff   <= ctrl.ext ? ~ext_gnt_n : gnt_ff[0];
			gnt_n_ff     <= ~gnt_ff[4:1];
			ext_req_n_ff <= ~(ctrl.ext & int_req);
			ext_sel_ff   <= ctrl.ext;
		end
	end

	assign int_gnt     = int_gnt_ff;
	assign gnt_n       = gnt_n_ff;
	assign ext_req_n   = ext_req_n_ff;
	assign ext_arb_sel = ext_sel_ff;

	// status for software
	assign stat.broken  = tmo_ff | broken_ff;
	assign stat.granted = gnt_ff;
	assign stat.own     = state_ff == ST_OWN;
endmodule // pci_bus_request_arbiter
`default_nettype wire

// ### shared/arb_pkg.sv
// constants and types for the secondary bus request arbiter
`default_nettype none
package arb_pkg;
	// requesters: 0 is the internal requester, 1 to 4 the external masters
	localparam int         NREQ        = 5;
	localparam int         IDX_W       = 3;

	// register offsets on the plain register port
	localparam logic [7:0] RSVD_OFS    = 8'h44;
	localparam logic [7:0] ARB_CTRL_OFS = 8'h48;
	localparam logic [7:0] ARB_STAT_OFS = 8'h80;

	// field positions inside bus_arbitration_control
	localparam int         EN_LSB      = 0;
	localparam int         EXT_BIT     = 9;
	localparam int         BMTO_BIT    = 10;
	localparam int         BMREF_BIT   = 11;
	localparam int         FAIR_LSB    = 12;
	localparam int         FAIR_W      = 8;
	localparam int         TOG_BIT     = 20;
	localparam int         PRIO_LSB    = 22;

	// reset value and writable bits of bus_arbitration_control
	localparam logic [31:0] CTRL_RST   = 32'h0040_801f;
	localparam logic [31:0] CTRL_WMASK = 32'h07df_fe1f;
	localparam logic [31:0] RSVD_RST   = 32'h0000_0000;

	// field positions inside the status word
	localparam int         ST_BROKEN_LSB = 0;
	localparam int         ST_GNT_LSB    = 5;
	localparam int         ST_OWN_BIT    = 10;

	// timing counts in bus clocks
	localparam int         BM_CYCLES   = 16;
	localparam logic [3:0] BM_LAST     = 4'(BM_CYCLES - 1);
	localparam int         TOG_DELAY   = 2;
	localparam logic [1:0] TOG_GAP_AT  = 2'(TOG_DELAY - 1);
	localparam logic [1:0] TOG_DONE    = 2'(TOG_DELAY);

	typedef struct packed {
		logic [NREQ-1:0]   prio;
		logic              tog;
		logic [FAIR_W-1:0] fair;
		logic              bm_ref;
		logic              bm_en;
		logic              ext;
		logic [NREQ-1:0]   en;
	} ctrl_t;

	typedef struct packed {
		logic              own;
		logic [NREQ-1:0]   granted;
		logic [NREQ-1:0]   broken;
	} stat_t;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_OWN} arb_state_t;

	// index of a requester to its one-hot bit
	function automatic logic [NREQ-1:0] idx_onehot(input logic [IDX_W-1:0] idx);
		idx_onehot = 5'h01 << idx;
	endfunction
endpackage
`default_nettype wire

// ### rtl/arb_regs.sv
// control and status registers of the bus arbiter on the plain register port
`default_nettype none
module arb_regs (
	input  wire logic            ref_clk,
	input  wire logic            srst,
	input  wire logic [7:0]      reg_addr,
	input  wire logic [31:0]     reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	input  wire arb_pkg::stat_t  stat,
	output logic [31:0]          reg_rdata,
	output arb_pkg::ctrl_t       ctrl
);
	import arb_pkg::*;

	logic [31:0] ctrl_ff;
	logic [31:0] rdata_ff;

	// read-only bits are masked on write so they always read zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_ff <= CTRL_RST;
		end else if (reg_wr && reg_addr == ARB_CTRL_OFS) begin
			ctrl_ff <= reg_wdata & CTRL_WMASK;
		end
	end

	// read data stands one cycle after the strobe and only then
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata_ff <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				ARB_CTRL_OFS: rdata_ff <= ctrl_ff;
				RSVD_OFS:     rdata_ff <= RSVD_RST;
				ARB_STAT_OFS: rdata_ff <= {21'h000000, stat};
				default:      rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	assign reg_rdata   = rdata_ff;
	assign ctrl.en     = ctrl_ff[EN_LSB +: NREQ];
	assign ctrl.ext    = ctrl_ff[EXT_BIT];
	assign ctrl.bm_en  = ctrl_ff[BMTO_BIT];
	assign ctrl.bm_ref = ctrl_ff[BMREF_BIT];
	assign ctrl.fair   = ctrl_ff[FAIR_LSB +: FAIR_W];
	assign ctrl.tog    = ctrl_ff[TOG_BIT];
	assign ctrl.prio   = ctrl_ff[PRIO_LSB +: NREQ];
endmodule // arb_regs
`default_nettype wire

// ### rtl/arb_pick.sv
// two-level rotating choice of the next bus owner
`default_nettype none
module arb_pick (
	input  wire logic [4:0] elig,
	input  wire logic [4:0] prio,
	input  wire logic [2:0] last,
	output logic            valid,
	output logic [2:0]      idx
);
	import arb_pkg::*;

	// first set bit after the last owner, wrapping; returns {found, index}
	function automatic logic [3:0] rr_first(input logic [NREQ-1:0] v, input logic [IDX_W-1:0] last_idx);
		logic [3:0] s;
		logic [3:0] r;
		r = 4'h0;
		for (int k = NREQ; k >= 1; k--) begin
			s = {1'b0, last_idx} + 4'(k);
			if (s >= 4'(NREQ)) begin
				s = s - 4'(NREQ);
			end
			if (v[s[2:0]]) begin
				r = {1'b1, s[2:0]};
			end
		end
		return r;
	endfunction

	logic [3:0] hi_pick;
	logic [3:0] lo_pick;

	// high level is served first, both levels rotate on from the same last owner
	assign hi_pick = rr_first(elig & prio, last);
	assign lo_pick = rr_first(elig & ~prio, last);
	assign valid   = hi_pick[3] | lo_pick[3];
	assign idx     = hi_pick[3] ? hi_pick[2:0] : lo_pick[2:0];
endmodule // arb_pick
`default_nettype wire

// ### tb/arb_chk.sv
// assertions on the arbiter pins
`default_nettype none
module arb_chk
	import arb_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        int_req,
	input wire logic [3:0]  req_n,
	input wire logic        frame_n,
	input wire logic        irdy_n,
	input wire logic        int_gnt,
	input wire logic [3:0]  gnt_n,
	input wire logic        ext_arb_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] ctl_ff;
	logic [4:0]  idle_ff;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// shadow of the control word, so checks follow what software set
	always_ff @(posedge ref_clk) begin
		if (srst)
			ctl_ff <= CTRL_RST;
		else if (reg_wr && reg_addr == ARB_CTRL_OFS)
			ctl_ff <= reg_wdata & CTRL_WMASK;
	end
	// cycles of a held grant on an idle bus, saturating
	always_ff @(posedge ref_clk) begin
		if (srst || (&gnt_n && !int_gnt) || !(frame_n && irdy_n))
			idle_ff <= 5'h00;
		else if (idle_ff != 5'h1f)
			idle_ff <= idle_ff + 5'h01;
	end
	sequence s_gap;
		##2 gnt_n[0] ##1 !gnt_n[0];
	endsequence
	property p_tog;
		ctl_ff[20] && !gnt_n[0] && $fell(frame_n) |-> s_gap;
	endproperty
	a_tog: assert property (p_tog) else $error("grant gap missing");
	property p_no_tog;
		!ctl_ff[20] && !gnt_n[0] && $fell(frame_n) && &req_n[3:1] && !int_req |=> !gnt_n[0];
	endproperty
	a_no_tog: assert property (p_no_tog) else $error("grant dropped in frame");
	property p_excl;
		$onehot0({int_gnt, ~gnt_n});
	endproperty
	a_excl: assert property (p_excl) else $error("two grants");
	property p_ext_sel;
		ext_arb_sel == $past(ctl_ff[9]);
	endproperty
	a_ext_sel: assert property (p_ext_sel) else $error("select wrong");
	property p_ext_quiet;
		ctl_ff[9] [*3] |-> &gnt_n;
	endproperty
	a_ext_quiet: assert property (p_ext_quiet) else $error("grant in outside mode");
	property p_drop;
		!gnt_n[0] && $rose(req_n[0]) |-> ##[1:2] gnt_n[0];
	endproperty
	a_drop: assert property (p_drop) else $error("grant kept");
	property p_en;
		(!ctl_ff[3]) [*3] |-> !$fell(gnt_n[2]);
	endproperty
	a_en: assert property (p_en) else $error("disabled master granted");
	property p_rd;
		reg_rd && reg_addr == ARB_CTRL_OFS |=> reg_rdata == $past(ctl_ff);
	endproperty
	a_rd: assert property (p_rd) else $error("control read wrong");
	property p_bm;
		ctl_ff[10] |-> idle_ff <= 5'h13;
	endproperty
	a_bm: assert property (p_bm) else $error("idle grant too long");
endmodule // arb_chk
`default_nettype wire

// ### tb/pci_masters.sv
// behavioural bus masters: internal requester and masters 1 to 4
`default_nettype none
module pci_masters (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic [4:0] post,
	input  wire logic [4:0] brk,
	input  wire logic [3:0] len,
	input  wire logic       slow,
	input  wire logic       int_gnt,
	input  wire logic [3:0] gnt_n,
	output logic            int_req,
	output logic [3:0]      req_n,
	output logic            frame_n,
	output logic            irdy_n,
	output var logic [4:0]  pend
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] g;
	logic [4:0] gq;
	logic [3:0] cnt;
	logic [2:0] own;
	logic       busy;
	logic       lag;
	assign g = {~gnt_n, int_gnt};
	assign int_req = pend[0];
	assign req_n = ~pend[4:1];
	// one frame per request; released lines go to the pull-up level
	always_ff @(posedge ref_clk) begin
		gq <= g;
		if (srst) begin
			pend <= 5'h00;
			busy <= 1'b0;
			lag <= 1'b0;
			frame_n <= 1'b1;
			irdy_n <= 1'b1;
		end else if (busy) begin
			pend <= pend | post;
			cnt <= cnt - 4'h1;
			if (cnt == 4'h1)
				frame_n <= 1'b1;
			if (cnt == 4'h0) begin
				irdy_n <= 1'b1;
				busy <= 1'b0;
				pend <= (pend | post) & ~(5'h01 << own);
			end
		end else begin
			// a stuck master gives up its request when the grant is taken
			pend <= (pend | post) & ~(brk & gq & ~g);
			if ((g & pend & ~brk) != 5'h00) begin
				lag <= slow & ~lag;
				if (!slow || lag) begin
					frame_n <= 1'b0;
					irdy_n <= 1'b0;
					busy <= 1'b1;
					cnt <= len;
					for (int i = 0; i < 5; i++)
						if (g[i])
							own <= 3'(i);
				end
			end
		end
	end
endmodule // pci_masters
`default_nettype wire

// ### tb/pci_bus_request_arbiter_bench.sv
// bench: registers, grant order, fairness, faults, outside mode
`default_nettype none
module pci_bus_request_arbiter_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import arb_pkg::*;
	logic        ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ext_gnt_n = 1'b1, slow = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, lf = 32'h5e97;
	logic [4:0]  post = 5'h00, brk = 5'h00, pend, g;
	logic [3:0]  len = 4'h3, req_n, gnt_n;
	logic        int_req, frame_n, irdy_n, int_gnt, ext_req_n, ext_arb_sel;
	int          n_fail = 0, num_checks = 0;
	assign g = {~gnt_n, int_gnt};
	always #2 ref_clk = ~ref_clk;
	pci_bus_request_arbiter pci_bus_request_arbiter_i (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .int_req, .req_n, .frame_n, .irdy_n, .ext_gnt_n, .int_gnt, .gnt_n, .ext_req_n, .ext_arb_sel);
	pci_masters pci_masters_i (.ref_clk, .srst, .post, .brk, .len, .slow, .int_gnt, .gnt_n, .int_req, .req_n,
		.frame_n, .irdy_n, .pend);
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// expected winner: high level first, rotating on from the last owner
	function automatic int pick(input logic [4:0] p, input logic [4:0] hi, input int last);
		int k;
		for (int l = 1; l >= 0; l--)
			for (int s = 1; s <= 5; s++) begin
				k = (last + s) % 5;
				if (p[k] && hi[k] == l[0])
					return k;
			end
		return -1;
	endfunction
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		chk(reg_rdata, e);
	endtask
	task automatic rq(input logic [4:0] m);
		post <= m;
		@(posedge ref_clk);
		post <= 5'h00;
	endtask
	task automatic wg(output int w, input int lim);
		w = -1;
		repeat (lim) begin
			@(posedge ref_clk);
			for (int i = 0; i < 5; i++)
				if (g[i])
					w = i;
			if (w >= 0)
				break;
		end
	endtask
	task automatic idle(input logic [4:0] q);
		repeat (100) begin
			if (g == 5'h00 && (pend & q) == 5'h00)
				break;
			@(posedge ref_clk);
		end
	endtask
	task automatic hold(input int w, output int n);
		n = 0;
		while (g[w] && n < 40) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	initial begin
		int w, n, last;
		logic [4:0] p, hi;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rc(ARB_CTRL_OFS, CTRL_RST);
		wr(RSVD_OFS, lf);
		rc(RSVD_OFS, RSVD_RST);
		rc(8'h4c, 32'h0);
		repeat (3) begin
			lf = lfsr(lf);
			wr(ARB_CTRL_OFS, lf);
			rc(ARB_CTRL_OFS, lf & CTRL_WMASK);
		end
		wr(ARB_CTRL_OFS, CTRL_RST);
		rq(5'h10);
		wg(w, 20);
		chk(w, 4);
		last = 4;
		hi = 5'h01;
		// random request sets under random priority levels
		repeat (12) begin
			lf = lfsr(lf);
			p = (lf[9:5] == 5'h00) ? 5'h1f : lf[9:5];
			len <= {2'b00, lf[11:10]} + 4'h2;
			slow <= lf[13];
			idle(5'h1f);
			rq(p);
			while (p != 5'h00) begin
				wg(w, 60);
				chk(w, pick(p, hi, last));
				if (w < 0)
					break;
				p[w] = 1'b0;
				last = w;
				idle(5'h00);
			end
			idle(5'h1f);
			hi = lf[26:22];
			wr(ARB_CTRL_OFS, (CTRL_RST & ~32'h07c0_0000) | {5'h00, hi, 22'h0});
		end
		// fairness zero holds the grant, a small value cuts it short
		len <= 4'hc;
		slow <= 1'b0;
		for (int f = 0; f < 3; f += 2) begin
			wr(ARB_CTRL_OFS, (CTRL_RST & ~32'h000f_f000) | (f << 12));
			rq(5'h06);
			wg(w, 20);
			hold(w, n);
			chk(f != 0 || n > 12, 1);
			chk(f == 0 || n < 9, 1);
			idle(5'h1f);
		end
		// stuck master: timeout, permanent exclusion, then refresh
		len <= 4'h3;
		brk <= 5'h04;
		wr(ARB_CTRL_OFS, CTRL_RST | 32'h400);
		rq(5'h04);
		wg(w, 20);
		hold(2, n);
		chk(n >= BM_CYCLES - 1 && n <= BM_CYCLES + 2, 1);
		rq(5'h04);
		wg(w, 40);
		chk(w, -1);
		brk <= 5'h00;
		wr(ARB_CTRL_OFS, CTRL_RST | 32'hc00);
		rq(5'h1b);
		idle(5'h1f);
		chk(pend, 5'h00);
		wr(ARB_CTRL_OFS, CTRL_RST & ~32'h8);
		rq(5'h08);
		wg(w, 30);
		chk(w, -1);
		wr(ARB_CTRL_OFS, CTRL_RST);
		wg(w, 30);
		chk(w, 3);
		idle(5'h1f);
		len <= 4'h6;
		for (int t = 0; t < 2; t++) begin
			wr(ARB_CTRL_OFS, CTRL_RST | (t << 20));
			rq(5'h02);
			idle(5'h1f);
		end
		// outside arbiter owns the grants
		wr(ARB_CTRL_OFS, CTRL_RST | 32'h200);
		rq(5'h03);
		repeat (3) @(posedge ref_clk);
		chk({ext_req_n, gnt_n}, 5'h0f);
		ext_gnt_n <= 1'b0;
		wg(w, 10);
		chk(w, 0);
		ext_gnt_n <= 1'b1;
		wr(ARB_CTRL_OFS, CTRL_RST);
		idle(5'h1f);
		chk(pend, 5'h00);
		conclude();
	end
	initial begin
		#100000;
		n_fail++;
		conclude();
	end
endmodule // pci_bus_request_arbiter_bench
bind pci_bus_request_arbiter arb_chk arb_chk_i (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .int_req, .req_n, .frame_n, .irdy_n, .int_gnt, .gnt_n, .ext_arb_sel);
`default_nettype wire
